/* design/pwm_ctrl_map.svh */
// register offsets, field positions and sizes of the pwm control block
// assumes a 16-bit register port with byte addresses
`ifndef PWM_CTRL_MAP_SVH
`define PWM_CTRL_MAP_SVH

`define GEN_COUNT        4
`define ADDR_SEV_CMP     8'h00
`define ADDR_MASTER_DUTY 8'h02
`define ADDR_POSTSCALE   8'h04
`define GEN_BASE_TAG     3'h1
`define GEN_OFS_CTRL     3'h0
`define GEN_OFS_DUTY     3'h2
`define GEN_OFS_PHASE    3'h4

`define GC_FLT_STAT      15
`define GC_CL_STAT       14
`define GC_TRG_STAT      13
`define GC_FLT_EN        12
`define GC_CL_EN         11
`define GC_TRG_EN        10
`define GC_ITB           9
`define GC_DUTY_SOURCE_SELECT          8
`define GC_DTC_HI        7
`define GC_DTC_LO        6
`define GC_EXTERNAL_TIMEBASE_RESET         1
`define GC_IUE           0

`define SEV_CMP_MASK     16'hFFF8
`define PHASE_MASK       16'hFFFC
`define PERIOD_MASK      16'hFFF0
`define POSTSCALE_MASK   16'h000F
`define REG_RESET        16'h0000

`endif

/* design/pwm_ctrl_pkg.sv */
// types shared by the pwm control block and its generator channels
// assumes nothing of its surroundings
`default_nettype none
package pwm_ctrl_pkg;

  typedef enum logic [1:0] {
    DT_POSITIVE = 2'h0,
    DT_NEGATIVE = 2'h1,
    DT_OFF      = 2'h2,
    DT_RESERVED = 2'h3
  } dead_time_e;

  typedef struct packed {
    logic       fault_irq_enable;
    logic       current_limit_irq_enable;
    logic       trigger_irq_enable;
    logic       independent_period_select;
    logic       duty_source_select;
    dead_time_e dead_time_mode;
    logic       external_timebase_reset;
    logic       immediate_duty_update;
  } gen_ctrl_s;

endpackage
`default_nettype wire

/* design/pwm_gen_channel.sv */
// one pwm generator: duty source, time base choice and duty latch
// assumes control, duty and phase registers from the parent block
`timescale 1ns/1ps
`default_nettype none
`include "pwm_ctrl_map.svh"

module pwm_gen_channel (
  input  wire logic                   core_clk,      // module clock
  input  wire logic                   reset_n,       // async, low
  input  wire pwm_ctrl_pkg::gen_ctrl_s ctrl,         // control fields
  input  wire logic [15:0]            own_duty,      // own duty reg
  input  wire logic [15:0]            master_duty,   // shared duty reg
  input  wire logic [15:0]            phase,         // phase register
  input  wire logic [15:0]            primary_count, // primary count
  input  wire logic                   primary_start, // primary wrap
  input  wire logic                   current_limit, // synced level
  output logic [15:0]                 active_duty,   // duty in use
  output logic                        pwm_high       // raw pwm level
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] active_reg;
  logic [15:0] active_next;
  logic        pwm_reg;
  logic        pwm_next;
  logic [15:0] period;
  logic [15:0] sel_duty;
  logic        wrap;
  logic        boundary;

  always_comb begin
    period = phase & `PERIOD_MASK;
    sel_duty = ctrl.duty_source_select ? master_duty : own_duty;
    wrap = count_reg >= period;
    count_next = 16'h0000;
    if (ctrl.independent_period_select) begin
      if (ctrl.external_timebase_reset && current_limit) begin
        count_next = 16'h0000;
      end else if (!wrap) begin
        count_next = count_reg + 16'h0001;
      end
    end
    boundary = ctrl.independent_period_select ? wrap : primary_start;
    active_next = active_reg;
    if (ctrl.immediate_duty_update || boundary) begin
      active_next = sel_duty;
    end
    pwm_next = (ctrl.independent_period_select ? count_reg
                : primary_count) < active_reg;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg  <= `REG_RESET;
      active_reg <= `REG_RESET;
      pwm_reg    <= 1'b0;
    end else begin
      count_reg  <= count_next;
      active_reg <= active_next;
      pwm_reg    <= pwm_next;
    end
  end

  assign active_duty = active_reg;
  assign pwm_high    = pwm_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_immediate;
    ctrl.immediate_duty_update |=> active_reg == $past(sel_duty);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate duty not taken");

  property p_synced_hold;
    !ctrl.immediate_duty_update && !boundary |=> $stable(active_reg);
  endproperty
  a_synced_hold: assert property (p_synced_hold)
    else $error("duty changed off boundary");

  property p_ext_reset;
    ctrl.independent_period_select && ctrl.external_timebase_reset
      && current_limit |=> count_reg == 16'h0000;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("time base not reset by current limit");

  property p_count_up;
    ctrl.independent_period_select && !wrap
      && !ctrl.external_timebase_reset
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("independent time base did not advance");

endmodule
`default_nettype wire

/* design/pwm_generator_control.sv */
// pwm generator control: registers, status flags, special event
// assumes a primary time base on the same clock feeding its count
// How it works
// - compare count bits 15-3, low bits zero
// - master duty is full 16-bit shared
// - each generator has own 16-bit duty
// - fault pending bit 15, cleared by enable
// - limit pending bit 14, cleared by enable
// - trigger pending bit 13, cleared by enable
// - bit 12 enables fault, else cleared
// - bit 11 enables limit, else cleared
// - bit 10 enables trigger, else cleared
// - bit 9 picks primary or phase period
// - bit 8 picks own or master duty
// - bits 7-6 pick dead-time mode
// - bit 1 lets current limit reset
// - bit 0 immediate, else synced duty load
// - control bits 5-2 read zero
// - special event postscale 1:1 to 1:16
// - phase bits 3-2 unused as period
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_ctrl_map.svh"

module pwm_generator_control (
  input  wire logic        core_clk,               // 20 MHz clock
  input  wire logic        reset_n,                // async, low
  input  wire logic [7:0]  addr,                   // byte address
  input  wire logic [15:0] wdata,                  // write data
  input  wire logic        wr,                     // write strobe
  input  wire logic        rd,                     // read strobe
  output logic [15:0]      rdata,                  // read data, +1
  input  wire logic [15:0] primary_timebase_count, // primary count
  input  wire logic        primary_cycle_start,    // primary wrap
  input  wire logic [3:0]  fault_pin,              // fault pins
  input  wire logic [3:0]  current_limit_pin,      // limit pins
  input  wire logic [3:0]  trigger_event,          // trigger pulses
  output logic [3:0]       pwm_high,               // raw pwm levels
  output logic [7:0]       dead_time_mode,         // 2 bits per gen
  output logic [3:0]       gen_irq,                // irq per gen
  output logic             special_event_trigger   // event pulse
);

  localparam int N = `GEN_COUNT;

  function automatic logic is_gen(input logic [7:0] a);
    return a[7:5] == `GEN_BASE_TAG;
  endfunction

  function automatic logic [1:0] gen_of(input logic [7:0] a);
    return a[4:3];
  endfunction

  function automatic pwm_ctrl_pkg::gen_ctrl_s
      ctrl_of(input logic [15:0] w);
    pwm_ctrl_pkg::gen_ctrl_s c;
    c.fault_irq_enable          = w[`GC_FLT_EN];
    c.current_limit_irq_enable  = w[`GC_CL_EN];
    c.trigger_irq_enable        = w[`GC_TRG_EN];
    c.independent_period_select = w[`GC_ITB];
    c.duty_source_select        = w[`GC_DUTY_SOURCE_SELECT];
    c.dead_time_mode            =
      pwm_ctrl_pkg::dead_time_e'(w[`GC_DTC_HI:`GC_DTC_LO]);
    c.external_timebase_reset   = w[`GC_EXTERNAL_TIMEBASE_RESET];
    c.immediate_duty_update     = w[`GC_IUE];
    return c;
  endfunction

  function automatic logic [15:0]
      word_of(input pwm_ctrl_pkg::gen_ctrl_s c,
              input logic [2:0] st);
    logic [15:0] w;
    w = 16'h0000;
    w[`GC_FLT_STAT]          = st[2];
    w[`GC_CL_STAT]           = st[1];
    w[`GC_TRG_STAT]          = st[0];
    w[`GC_FLT_EN]            = c.fault_irq_enable;
    w[`GC_CL_EN]             = c.current_limit_irq_enable;
    w[`GC_TRG_EN]            = c.trigger_irq_enable;
    w[`GC_ITB]               = c.independent_period_select;
    w[`GC_DUTY_SOURCE_SELECT]              = c.duty_source_select;
    w[`GC_DTC_HI:`GC_DTC_LO] = c.dead_time_mode;
    w[`GC_EXTERNAL_TIMEBASE_RESET]             = c.external_timebase_reset;
    w[`GC_IUE]               = c.immediate_duty_update;
    return w;
  endfunction

  // registers
  logic [15:0]             sev_reg, sev_next;
  logic [15:0]             mdc_reg, mdc_next;
  logic [3:0]              ps_reg, ps_next;
  pwm_ctrl_pkg::gen_ctrl_s ctrl_reg [N], ctrl_next [N];
  logic [15:0]             duty_reg [N], duty_next [N];
  logic [15:0]             phase_reg [N], phase_next [N];
  logic [15:0]             rdata_reg, rdata_next;
  // status flags: bit 2 fault, 1 limit, 0 trigger
  logic [2:0]              stat_reg [N], stat_next [N];
  // pin synchronisers and edge history
  logic [3:0]              flt_meta_reg, flt_sync_reg, flt_prev_reg;
  logic [3:0]              cl_meta_reg, cl_sync_reg, cl_prev_reg;
  // special event
  logic                    match, hit, match_reg;
  logic [3:0]              pcnt_reg, pcnt_next;
  logic                    sev_trig_reg, sev_trig_next;
  logic [3:0]              flt_evt, cl_evt;
  logic                    gsel;
  logic [1:0]              gidx;

  always_comb begin
    gsel = is_gen(addr);
    gidx = gen_of(addr);
    flt_evt = flt_sync_reg & ~flt_prev_reg;
    cl_evt  = cl_sync_reg & ~cl_prev_reg;
    sev_next = sev_reg;
    mdc_next = mdc_reg;
    ps_next  = ps_reg;
    if (wr && addr == `ADDR_SEV_CMP) begin
      sev_next = wdata & `SEV_CMP_MASK;
    end
    if (wr && addr == `ADDR_MASTER_DUTY) begin
      mdc_next = wdata;
    end
    if (wr && addr == `ADDR_POSTSCALE) begin
      ps_next = wdata[3:0];
    end
    for (int i = 0; i < N; i++) begin
      ctrl_next[i]  = ctrl_reg[i];
      duty_next[i]  = duty_reg[i];
      phase_next[i] = phase_reg[i];
      if (wr && gsel && gidx == 2'(i)) begin
        case (addr[2:0])
          `GEN_OFS_CTRL:  ctrl_next[i] = ctrl_of(wdata);
          `GEN_OFS_DUTY:  duty_next[i] = wdata;
          `GEN_OFS_PHASE: phase_next[i] = wdata & `PHASE_MASK;
          default:        ;
        endcase
      end
      stat_next[i][2] = ctrl_next[i].fault_irq_enable
                        && (stat_reg[i][2] || flt_evt[i]);
      stat_next[i][1] = ctrl_next[i].current_limit_irq_enable
                        && (stat_reg[i][1] || cl_evt[i]);
      stat_next[i][0] = ctrl_next[i].trigger_irq_enable
                        && (stat_reg[i][0] || trigger_event[i]);
    end
    rdata_next = 16'h0000;
    if (rd) begin
      if (addr == `ADDR_SEV_CMP) begin
        rdata_next = sev_reg;
      end else if (addr == `ADDR_MASTER_DUTY) begin
        rdata_next = mdc_reg;
      end else if (addr == `ADDR_POSTSCALE) begin
        rdata_next = {12'h000, ps_reg};
      end else if (gsel) begin
        case (addr[2:0])
          `GEN_OFS_CTRL:
            rdata_next = word_of(ctrl_reg[gidx], stat_reg[gidx]);
          `GEN_OFS_DUTY:  rdata_next = duty_reg[gidx];
          `GEN_OFS_PHASE: rdata_next = phase_reg[gidx];
          default:        rdata_next = 16'h0000;
        endcase
      end
    end
  end

  always_comb begin
    match = (primary_timebase_count & `SEV_CMP_MASK) == sev_reg;
    hit = match && !match_reg;
    pcnt_next = pcnt_reg;
    sev_trig_next = 1'b0;
    if (hit) begin
      // >= so a count left above a lowered postscale still fires
      if (pcnt_reg >= ps_reg) begin
        pcnt_next = 4'h0;
        sev_trig_next = 1'b1;
      end else begin
        pcnt_next = pcnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sev_reg      <= `REG_RESET;
      mdc_reg      <= `REG_RESET;
      ps_reg       <= 4'h0;
      rdata_reg    <= `REG_RESET;
      flt_meta_reg <= 4'h0;
      flt_sync_reg <= 4'h0;
      flt_prev_reg <= 4'h0;
      cl_meta_reg  <= 4'h0;
      cl_sync_reg  <= 4'h0;
      cl_prev_reg  <= 4'h0;
      match_reg    <= 1'b0;
      pcnt_reg     <= 4'h0;
      sev_trig_reg <= 1'b0;
      for (int i = 0; i < N; i++) begin
        ctrl_reg[i]  <= '0;
        duty_reg[i]  <= `REG_RESET;
        phase_reg[i] <= `REG_RESET;
        stat_reg[i]  <= 3'h0;
      end
    end else begin
      sev_reg      <= sev_next;
      mdc_reg      <= mdc_next;
      ps_reg       <= ps_next;
      rdata_reg    <= rdata_next;
      flt_meta_reg <= fault_pin;
      flt_sync_reg <= flt_meta_reg;
      flt_prev_reg <= flt_sync_reg;
      cl_meta_reg  <= current_limit_pin;
      cl_sync_reg  <= cl_meta_reg;
      cl_prev_reg  <= cl_sync_reg;
      match_reg    <= match;
      pcnt_reg     <= pcnt_next;
      sev_trig_reg <= sev_trig_next;
      for (int i = 0; i < N; i++) begin
        ctrl_reg[i]  <= ctrl_next[i];
        duty_reg[i]  <= duty_next[i];
        phase_reg[i] <= phase_next[i];
        stat_reg[i]  <= stat_next[i];
      end
    end
  end

  for (genvar g = 0; g < N; g++) begin : gen_ch
    pwm_gen_channel u_ch (
      .core_clk      (core_clk),
      .reset_n       (reset_n),
      .ctrl          (ctrl_reg[g]),
      .own_duty      (duty_reg[g]),
      .master_duty   (mdc_reg),
      .phase         (phase_reg[g]),
      .primary_count (primary_timebase_count),
      .primary_start (primary_cycle_start),
      .current_limit (cl_sync_reg[g]),
      .active_duty   (),
      .pwm_high      (pwm_high[g])
    );
    assign dead_time_mode[2*g+1:2*g] = ctrl_reg[g].dead_time_mode;
    assign gen_irq[g] = |(stat_reg[g] & {
      ctrl_reg[g].fault_irq_enable,
      ctrl_reg[g].current_limit_irq_enable,
      ctrl_reg[g].trigger_irq_enable});
  end

  assign rdata = rdata_reg;
  assign special_event_trigger = sev_trig_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_sev_low_zero;
    rd && addr == `ADDR_SEV_CMP |=> rdata[2:0] == 3'h0;
  endproperty
  a_sev_low_zero: assert property (p_sev_low_zero)
    else $error("compare low bits not zero");

  property p_ctrl_gap_zero;
    rd && gsel && addr[2:0] == `GEN_OFS_CTRL |=> rdata[5:2] == 4'h0;
  endproperty
  a_ctrl_gap_zero: assert property (p_ctrl_gap_zero)
    else $error("control bits 5-2 not zero");

  property p_mdc_read;
    wr && addr == `ADDR_MASTER_DUTY ##1 rd && addr == `ADDR_MASTER_DUTY
      |=> rdata == $past(wdata, 2);
  endproperty
  a_mdc_read: assert property (p_mdc_read)
    else $error("master duty readback wrong");

  property p_fault_set;
    ctrl_reg[0].fault_irq_enable && flt_evt[0]
      && !(wr && gsel && gidx == 2'h0 && addr[2:0] == `GEN_OFS_CTRL)
      |=> stat_reg[0][2];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault event lost");

  property p_fault_held_clear;
    !ctrl_reg[0].fault_irq_enable |-> !stat_reg[0][2];
  endproperty
  a_fault_held_clear: assert property (p_fault_held_clear)
    else $error("fault flag set while disabled");

  property p_cl_held_clear;
    !ctrl_reg[1].current_limit_irq_enable |-> !stat_reg[1][1];
  endproperty
  a_cl_held_clear: assert property (p_cl_held_clear)
    else $error("limit flag set while disabled");

  property p_trg_set;
    ctrl_reg[2].trigger_irq_enable && trigger_event[2]
      && !(wr && gsel) |=> stat_reg[2][0] ##0 gen_irq[2];
  endproperty
  a_trg_set: assert property (p_trg_set)
    else $error("trigger not raising irq");

  property p_irq_none;
    stat_reg[3] == 3'h0 |-> !gen_irq[3];
  endproperty
  a_irq_none: assert property (p_irq_none)
    else $error("irq without pending flag");

  sequence s_one_to_one;
    ps_reg == 4'h0 && hit;
  endsequence
  sequence s_fire;
    ##1 special_event_trigger ##1 !special_event_trigger;
  endsequence
  property p_post_one;
    s_one_to_one |-> s_fire;
  endproperty
  a_post_one: assert property (p_post_one)
    else $error("1:1 postscale did not fire once");
  property p_post_skip;
    hit && pcnt_reg < ps_reg |=> !special_event_trigger;
  endproperty
  a_post_skip: assert property (p_post_skip)
    else $error("event fired before postscale count");

endmodule
`default_nettype wire

/* tb/test_pwm_generator_control.sv */
// self-checking bench for the pwm generator control block
// assumes the block's register map header and a 20 MHz module clock
`timescale 1ns/1ps
`default_nettype none
`include "pwm_ctrl_map.svh"

module test_pwm_generator_control;
  logic        core_clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [15:0] primary_timebase_count;
  logic        primary_cycle_start;
  logic [3:0]  fault_pin;
  logic [3:0]  current_limit_pin;
  logic [3:0]  trigger_event;
  logic [3:0]  pwm_high;
  logic [7:0]  dead_time_mode;
  logic [3:0]  gen_irq;
  logic        special_event_trigger;
  int          err_total;
  int          checked;
  int          cycles;
  int          sev_seen;
  logic [15:0] rv;

  pwm_generator_control u_pwm_generator_control (
    .core_clk               (core_clk),
    .reset_n                (reset_n),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr                     (wr),
    .rd                     (rd),
    .rdata                  (rdata),
    .primary_timebase_count (primary_timebase_count),
    .primary_cycle_start    (primary_cycle_start),
    .fault_pin              (fault_pin),
    .current_limit_pin      (current_limit_pin),
    .trigger_event          (trigger_event),
    .pwm_high               (pwm_high),
    .dead_time_mode         (dead_time_mode),
    .gen_irq                (gen_irq),
    .special_event_trigger  (special_event_trigger)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // scenarios need about 600 cycles; a hang stops well past that
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (special_event_trigger === 1'b1) begin
      sev_seen = sev_seen + 1;
    end
    if (cycles == 20000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] gen_addr(input int g, input logic [2:0] o);
    return 8'h20 + 8'(g * 8) + {5'h00, o};
  endfunction

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic t_reset_values();
    logic [7:0] a [5] = '{8'h00, 8'h02, 8'h04, 8'h20, 8'h3A};
    for (int i = 0; i < 5; i++) begin
      reg_read(a[i], rv);
      check(rv, 16'h0000); // cleared at reset
    end
  endtask

  task automatic t_data_regs();
    reg_write(`ADDR_SEV_CMP, 16'hFFFF);
    reg_read(`ADDR_SEV_CMP, rv);
    check(rv, 16'hFFF8); // low three bits read zero
    // write then read with no gap between the strobes
    @(posedge core_clk);
    addr  <= `ADDR_MASTER_DUTY;
    wdata <= 16'hFFEF;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge core_clk);
    rd    <= 1'b0;
    #1;
    check(rdata, 16'hFFEF); // read right behind write
    for (int g = 0; g < 4; g++) begin
      reg_write(gen_addr(g, `GEN_OFS_DUTY), 16'h0008 + 16'(g));
    end
    reg_read(`ADDR_MASTER_DUTY, rv);
    check(rv, 16'hFFEF); // full width, all bits set but bit 4
    for (int g = 0; g < 4; g++) begin
      reg_read(gen_addr(g, `GEN_OFS_DUTY), rv);
      check(rv, 16'h0008 + 16'(g)); // one per generator
    end
    reg_write(gen_addr(3, `GEN_OFS_CTRL), 16'hFFFF);
    reg_read(gen_addr(3, `GEN_OFS_CTRL), rv);
    check(rv, 16'h1FC3); // unused and status bits
    reg_write(8'h06, 16'hFFFF);
    reg_read(8'h06, rv);
    check(rv, 16'h0000); // stray write lands nowhere
    reg_write(`ADDR_POSTSCALE, 16'hFFFF);
    reg_read(`ADDR_POSTSCALE, rv);
    check(rv, 16'h000F); // four-bit field
  endtask

  task automatic t_dead_time();
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 4; c++) begin
        reg_write(gen_addr(g, `GEN_OFS_CTRL), 16'(c << 6));
        @(posedge core_clk);
        #1;
        check({14'h0, dead_time_mode[2*g +: 2]}, 16'(c)); // mode
      end
    end
  endtask

  // pins are held three cycles so the synchroniser sees the rise
  task automatic fire(input int g, input int k);
    logic [3:0] m;
    m = 4'h1 << g;
    @(posedge core_clk);
    trigger_event     <= (k == 2) ? m : 4'h0;
    current_limit_pin <= (k == 1) ? m : 4'h0;
    fault_pin         <= (k == 0) ? m : 4'h0;
    @(posedge core_clk);
    trigger_event     <= 4'h0;
    repeat (2) @(posedge core_clk);
    current_limit_pin <= 4'h0;
    fault_pin         <= 4'h0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic t_status(input int g, input int k);
    logic [15:0] en;
    logic [15:0] st;
    en = 16'h0001 << (12 - k);
    st = 16'h0001 << (15 - k);
    reg_write(gen_addr(g, `GEN_OFS_CTRL), en);
    fire(g, k);
    reg_read(gen_addr(g, `GEN_OFS_CTRL), rv);
    check(rv, en | st); // flag set
    check({15'h0, gen_irq[g]}, 16'h0001); // request raised
    reg_write(gen_addr(g, `GEN_OFS_CTRL), 16'h0000);
    reg_read(gen_addr(g, `GEN_OFS_CTRL), rv);
    check(rv, 16'h0000); // cleared with enable
    check({15'h0, gen_irq[g]}, 16'h0000); // request dropped
    fire(g, k);
    reg_read(gen_addr(g, `GEN_OFS_CTRL), rv);
    check(rv, 16'h0000); // ignored when off
  endtask

  task automatic t_sev(input logic [3:0] ps, input int n, input int exp);
    reg_write(`ADDR_SEV_CMP, 16'h0010);
    reg_write(`ADDR_POSTSCALE, {12'h000, ps});
    #1;
    sev_seen = 0;
    repeat (n) begin
      @(posedge core_clk);
      primary_timebase_count <= 16'h0013;
      @(posedge core_clk);
      primary_timebase_count <= 16'h1234;
    end
    repeat (3) @(posedge core_clk);
    check(16'(sev_seen), 16'(exp)); // postscaled matches
  endtask

  task automatic look(input logic exp);
    repeat (4) @(posedge core_clk);
    #1;
    check({15'h0, pwm_high[0]}, {15'h0, exp}); // pwm level
  endtask

  task automatic t_duty();
    reg_write(gen_addr(0, `GEN_OFS_CTRL), 16'h0001);
    reg_write(gen_addr(0, `GEN_OFS_DUTY), 16'h0100);
    primary_timebase_count <= 16'h0050;
    look(1'b1); // immediate load
    reg_write(gen_addr(0, `GEN_OFS_CTRL), 16'h0000);
    reg_write(gen_addr(0, `GEN_OFS_DUTY), 16'h0020);
    look(1'b1); // held until boundary
    @(posedge core_clk);
    primary_cycle_start <= 1'b1;
    @(posedge core_clk);
    primary_cycle_start <= 1'b0;
    look(1'b0); // loaded at boundary
    reg_write(`ADDR_MASTER_DUTY, 16'h0080);
    reg_write(gen_addr(0, `GEN_OFS_CTRL), 16'h0101);
    look(1'b1); // master duty in use
    reg_write(`ADDR_MASTER_DUTY, 16'h0040);
    look(1'b0); // master value followed
    reg_write(gen_addr(0, `GEN_OFS_DUTY), 16'h0100);
    reg_write(gen_addr(0, `GEN_OFS_CTRL), 16'h0001);
    look(1'b1); // own duty again
  endtask

  // counts how many of n cycles generator 1 drives high
  task automatic highs(input int n, input int exp);
    int ones;
    ones = 0;
    repeat (4) @(posedge core_clk);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      ones += (pwm_high[1] === 1'b1) ? 1 : 0;
    end
    check(16'(ones), 16'(exp)); // high count
  endtask

  task automatic t_indep();
    reg_write(gen_addr(1, `GEN_OFS_PHASE), 16'h001C);
    reg_write(gen_addr(1, `GEN_OFS_DUTY), 16'h0008);
    current_limit_pin <= 4'h2;
    primary_timebase_count <= 16'hF000;
    reg_write(gen_addr(1, `GEN_OFS_CTRL), 16'h0201);
    highs(34, 16); // period 17, pin ignored
    reg_write(gen_addr(1, `GEN_OFS_CTRL), 16'h0203);
    highs(17, 17); // limit holds time base at zero
    @(posedge core_clk);
    current_limit_pin <= 4'h0;
  endtask

  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    primary_timebase_count = 16'h1234;
    primary_cycle_start = 1'b0;
    fault_pin = 4'h0;
    current_limit_pin = 4'h0;
    trigger_event = 4'h0;
    err_total = 0;
    checked = 0;
    cycles = 0;
    sev_seen = 0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_data_regs();
    t_dead_time();
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 3; k++) begin
        t_status(g, k);
      end
    end
    t_sev(4'h0, 3, 3);
    t_sev(4'h3, 8, 2);
    t_sev(4'hF, 16, 1);
    t_duty();
    t_indep();
    test_done();
  end
endmodule
`default_nettype wire
